// ---- logic/irqm_config.sv ----
// interrupt pin mapping, sample threshold and filter configuration registers
//
// Overview of operation
// - threshold is nine bits, upper bit from fifo config, range 0 to 511
// - sample threshold register resets to 0x80
// - each of seven low map bits routes its status function to the pin
// - map bit 7 picks polarity: zero active high, one active low
// - all mapped functions of a pin are ORed onto it
// - a pin with nothing mapped is released to high impedance
// - every status function is readable regardless of mapping
// - map bits: awake, stillness, motion, overrun, watermark, fifo ready, data ready
// - second map register drives pin two with same layout, resets to zero
// - range field 7:6 selects 2 g, 4 g or 8 g full scale
// - narrow band bit resets to one; one gives quarter rate, zero half
// - external trigger bit turns pin two into a conversion timing input
// - rate field selects 12.5 Hz doubling to 200 Hz, higher codes 400 Hz
// - upper threshold bit lives at fifo config bit 3, resets to zero
`timescale 1ns/10ps
module irqm_config
    import irqm_pkg::*;
#(
    parameter int RATE_CYCLES = RATE_BASE_CYCLES,
    parameter int TIMER_WIDTH = 24
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire irqm_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire irqm_status_s status,
    output logic irq_pin_one_out,
    output logic irq_pin_one_oe_n,
    input wire logic irq_pin_two_in,
    output logic irq_pin_two_out,
    output logic irq_pin_two_oe_n,
    output logic [8:0] fifo_threshold,
    output logic [3:0] full_scale_g,
    output logic [2:0] bandwidth_divisor,
    output logic conversion_start
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    initial begin
        if (RATE_CYCLES < 1 || TIMER_WIDTH > 31) begin
            $error("irqm_config: bad timer parameters");
        end
        if ((64'(RATE_CYCLES) << (RATE_CODE_FASTEST + 3'h1)) >= (64'h1 << TIMER_WIDTH)) begin
            $error("irqm_config: timer too narrow for slowest rate");
        end
    end

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [TIMER_WIDTH-1:0] rate_period(input logic [2:0] code);
        logic [2:0] shift;
        // highest doubling code runs at half the fastest rate
        shift = (code > RATE_CODE_FASTEST) ? 3'h0 : RATE_CODE_FASTEST + 3'h1 - code;
        rate_period = TIMER_WIDTH'(RATE_CYCLES) << shift;
    endfunction : rate_period

    function automatic logic [3:0] scale_of(input logic [1:0] range);
        if (range == RANGE_2G) begin
            scale_of = SCALE_2G;
        end else if (range == RANGE_4G) begin
            scale_of = SCALE_4G;
        end else begin
            scale_of = SCALE_8G;
        end
    endfunction : scale_of

    function automatic logic hit(input logic [7:0] offset);
        hit = reg_req.addr == offset;
    endfunction : hit

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] sample_threshold;
    logic count_upper_bit;
    logic [7:0] pin_one_map;
    logic [7:0] pin_two_map;
    logic [7:0] filter_config;
    logic narrow_band_select;
    logic external_trigger_select;
    logic [2:0] output_rate_select;
    logic [1:0] range_select;

    assign narrow_band_select = filter_config[NARROW_BAND_POS];
    assign external_trigger_select = filter_config[EXT_TRIGGER_POS];
    assign output_rate_select = filter_config[RATE_MSB:RATE_LSB];
    assign range_select = filter_config[RANGE_MSB:RANGE_LSB];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_threshold <= RST_SAMPLE_THRESHOLD;
        end else if (reg_req.we && hit(ADDR_SAMPLE_THRESHOLD)) begin
            sample_threshold <= reg_req.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_upper_bit <= RST_COUNT_UPPER_BIT;
        end else if (reg_req.we && hit(ADDR_FIFO_CONFIG)) begin
            count_upper_bit <= reg_req.wdata[COUNT_UPPER_BIT_POS];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_one_map <= RST_PIN_MAP;
        end else if (reg_req.we && hit(ADDR_PIN_ONE_MAP)) begin
            pin_one_map <= reg_req.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_two_map <= RST_PIN_MAP;
        end else if (reg_req.we && hit(ADDR_PIN_TWO_MAP)) begin
            pin_two_map <= reg_req.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filter_config <= RST_FILTER_CONFIG;
        end else if (reg_req.we && hit(ADDR_FILTER_CONFIG)) begin
            filter_config <= reg_req.wdata;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_req.addr)
            ADDR_STATUS_MIRROR: next_rdata = {1'b0, status};
            ADDR_FIFO_CONFIG: next_rdata = 8'(count_upper_bit) << COUNT_UPPER_BIT_POS;
            ADDR_SAMPLE_THRESHOLD: next_rdata = sample_threshold;
            ADDR_PIN_ONE_MAP: next_rdata = pin_one_map;
            ADDR_PIN_TWO_MAP: next_rdata = pin_two_map;
            ADDR_FILTER_CONFIG: next_rdata = filter_config;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.re) begin
            reg_rdata <= next_rdata;
        end
    end

    // ************************************************************
    // decoded configuration
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_threshold <= {RST_COUNT_UPPER_BIT, RST_SAMPLE_THRESHOLD};
        end else begin
            fifo_threshold <= {count_upper_bit, sample_threshold};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            full_scale_g <= SCALE_2G;
        end else begin
            full_scale_g <= scale_of(range_select);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bandwidth_divisor <= BW_DIV_QUARTER;
        end else begin
            bandwidth_divisor <= narrow_band_select ? BW_DIV_QUARTER : BW_DIV_HALF;
        end
    end

    // ************************************************************
    // conversion timing
    // ************************************************************
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic [TIMER_WIDTH-1:0] rate_timer;
    logic rate_tick;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_meta <= irq_pin_two_in;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    assign rate_tick = rate_timer == '0;

    // rate change takes effect at the next reload
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_timer <= '0;
        end else if (rate_tick) begin
            rate_timer <= rate_period(output_rate_select) - TIMER_WIDTH'(1);
        end else begin
            rate_timer <= rate_timer - TIMER_WIDTH'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_start <= 1'b0;
        end else if (external_trigger_select) begin
            conversion_start <= trig_sync && !trig_prev;
        end else begin
            conversion_start <= rate_tick;
        end
    end

    // ************************************************************
    // pin drivers
    // ************************************************************
    irqm_pin_drive u_pin_one (
        .clk(clk),
        .rst_n(rst_n),
        .pin_map(pin_one_map),
        .status(status),
        .release_pin(1'b0),
        .pin_out(irq_pin_one_out),
        .pin_oe_n(irq_pin_one_oe_n)
    );

    irqm_pin_drive u_pin_two (
        .clk(clk),
        .rst_n(rst_n),
        .pin_map(pin_two_map),
        .status(status),
        .release_pin(external_trigger_select),
        .pin_out(irq_pin_two_out),
        .pin_oe_n(irq_pin_two_oe_n)
    );

    // ************************************************************
    // checks
    // ************************************************************
    property p_threshold_write;
        @(posedge clk) disable iff (!rst_n)
        (reg_req.we && reg_req.addr == ADDR_SAMPLE_THRESHOLD) |=> ##1 (fifo_threshold[7:0] == $past(reg_req.wdata, 2));
    endproperty
    a_threshold_write: assert property (p_threshold_write) else $error("threshold low byte not updated");

    property p_upper_bit_write;
        @(posedge clk) disable iff (!rst_n)
        (reg_req.we && reg_req.addr == ADDR_FIFO_CONFIG) |=> ##1
        (fifo_threshold[8] == $past(reg_req.wdata[COUNT_UPPER_BIT_POS], 2));
    endproperty
    a_upper_bit_write: assert property (p_upper_bit_write) else $error("threshold upper bit not from bit 3");

    property p_map_readback;
        @(posedge clk) disable iff (!rst_n)
        (reg_req.we && reg_req.addr == ADDR_PIN_TWO_MAP) ##1 !reg_req.we
        ##1 (reg_req.re && !reg_req.we && reg_req.addr == ADDR_PIN_TWO_MAP)
        |=> (reg_rdata == $past(reg_req.wdata, 3));
    endproperty
    a_map_readback: assert property (p_map_readback) else $error("pin two map read back differs");

    property p_status_read;
        @(posedge clk) disable iff (!rst_n)
        (reg_req.re && reg_req.addr == ADDR_STATUS_MIRROR) |=> (reg_rdata[6:0] == $past(status));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status mirror wrong");

    property p_range_decode;
        @(posedge clk) disable iff (!rst_n)
        ##1 (full_scale_g == (($past(range_select) == 2'h0) ? 4'h2 : ($past(range_select) == 2'h1) ? 4'h4 : 4'h8));
    endproperty
    a_range_decode: assert property (p_range_decode) else $error("full scale decode wrong");

    property p_bandwidth;
        @(posedge clk) disable iff (!rst_n)
        ##1 (bandwidth_divisor == ($past(narrow_band_select) ? 3'h4 : 3'h2));
    endproperty
    a_bandwidth: assert property (p_bandwidth) else $error("bandwidth divisor wrong");

    property p_ext_release;
        @(posedge clk) disable iff (!rst_n)
        external_trigger_select |=> irq_pin_two_oe_n;
    endproperty
    a_ext_release: assert property (p_ext_release) else $error("pin two driven in trigger mode");

    property p_ext_start;
        @(posedge clk) disable iff (!rst_n)
        (external_trigger_select && trig_sync && !trig_prev) |=> conversion_start;
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("trigger edge did not start conversion");

    property p_rate_reload;
        @(posedge clk) disable iff (!rst_n)
        rate_tick |=> (int'(rate_timer) + 1 == (($past(output_rate_select) > RATE_CODE_FASTEST) ? RATE_CYCLES :
            RATE_CYCLES << (int'(RATE_CODE_FASTEST) + 1 - int'($past(output_rate_select)))));
    endproperty
    a_rate_reload: assert property (p_rate_reload) else $error("rate period wrong");

endmodule : irqm_config

// ---- logic/irqm_pin_drive.sv ----
// driver of one mapped interrupt pin
`timescale 1ns/10ps
module irqm_pin_drive
    import irqm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] pin_map,
    input wire irqm_status_s status,
    input wire logic release_pin,
    output logic pin_out,
    output logic pin_oe_n
);

    logic any_mapped;
    logic any_active;

    assign any_mapped = |pin_map[MAP_ACTIVE_LOW_POS-1:0];
    assign any_active = |(pin_map[MAP_ACTIVE_LOW_POS-1:0] & status);

    // ************************************************************
    // pin level and enable
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_oe_n <= 1'b1;
        end else begin
            pin_oe_n <= !any_mapped || release_pin;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= any_active ^ pin_map[MAP_ACTIVE_LOW_POS];
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_unmapped_released;
        @(posedge clk) disable iff (!rst_n)
        (pin_map[MAP_ACTIVE_LOW_POS-1:0] == 7'h00) |=> pin_oe_n;
    endproperty
    a_unmapped_released: assert property (p_unmapped_released) else $error("unmapped pin is driven");

    property p_quiet_level;
        @(posedge clk) disable iff (!rst_n)
        (any_mapped && !any_active && !release_pin) |=> (!pin_oe_n && (pin_out == $past(pin_map[MAP_ACTIVE_LOW_POS])));
    endproperty
    a_quiet_level: assert property (p_quiet_level) else $error("idle pin level disagrees with polarity");

    property p_or_active;
        @(posedge clk) disable iff (!rst_n)
        (any_active && !release_pin) |=> (!pin_oe_n && (pin_out != $past(pin_map[MAP_ACTIVE_LOW_POS])));
    endproperty
    a_or_active: assert property (p_or_active) else $error("mapped active condition not shown on pin");

    property p_data_ready_bit;
        @(posedge clk) disable iff (!rst_n)
        (pin_map[0] && status.data_ready && !pin_map[MAP_ACTIVE_LOW_POS]) |=> pin_out;
    endproperty
    a_data_ready_bit: assert property (p_data_ready_bit) else $error("bit 0 does not map data ready");

endmodule : irqm_pin_drive

// ---- logic/irqm_pkg.sv ----
// package of register map, field layout and carrier types for the interrupt map block
package irqm_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_STATUS_MIRROR = 8'h0b;
    localparam logic [7:0] ADDR_FIFO_CONFIG = 8'h28;
    localparam logic [7:0] ADDR_SAMPLE_THRESHOLD = 8'h29;
    localparam logic [7:0] ADDR_PIN_ONE_MAP = 8'h2a;
    localparam logic [7:0] ADDR_PIN_TWO_MAP = 8'h2b;
    localparam logic [7:0] ADDR_FILTER_CONFIG = 8'h2c;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_SAMPLE_THRESHOLD = 8'h80;
    localparam logic [7:0] RST_PIN_MAP = 8'h00;
    localparam logic [7:0] RST_FILTER_CONFIG = 8'h13;
    localparam logic RST_COUNT_UPPER_BIT = 1'b0;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int COUNT_UPPER_BIT_POS = 3;
    localparam int MAP_ACTIVE_LOW_POS = 7;
    localparam int RANGE_MSB = 7;
    localparam int RANGE_LSB = 6;
    localparam int NARROW_BAND_POS = 4;
    localparam int EXT_TRIGGER_POS = 3;
    localparam int RATE_MSB = 2;
    localparam int RATE_LSB = 0;

    // ************************************************************
    // field encodings
    // ************************************************************
    localparam logic [1:0] RANGE_2G = 2'h0;
    localparam logic [1:0] RANGE_4G = 2'h1;
    localparam logic [3:0] SCALE_2G = 4'h2;
    localparam logic [3:0] SCALE_4G = 4'h4;
    localparam logic [3:0] SCALE_8G = 4'h8;
    localparam logic [2:0] BW_DIV_HALF = 3'h2;
    localparam logic [2:0] BW_DIV_QUARTER = 3'h4;
    localparam logic [2:0] RATE_CODE_FASTEST = 3'h4;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ = 40000000;
    localparam int RATE_MAX_HZ = 400;
    localparam int RATE_BASE_CYCLES = CLK_HZ / RATE_MAX_HZ;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic awake;
        logic stillness;
        logic motion;
        logic fifo_overrun;
        logic fifo_watermark;
        logic fifo_ready;
        logic data_ready;
    } irqm_status_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } irqm_reg_req_s;

endpackage : irqm_pkg

// ---- verification/irqm_host_model.sv ----
// host side model: interrupt pin wires with keepers and an external trigger source
`timescale 1ns/10ps
module irqm_host_model (
    input wire logic clk,
    input wire logic pin_one_out,
    input wire logic pin_one_oe_n,
    input wire logic pin_two_out,
    input wire logic pin_two_oe_n,
    input wire logic trig_en,
    output logic pin_one_level,
    output logic pin_two_level
);
    logic keep_one = 1'b0;
    logic keep_two = 1'b0;
    logic trig_lvl = 1'b0;
    logic [1:0] trig_cnt = 2'h0;

    // ************************************************************
    // wire resolution, keeper holds the last driven level
    // ************************************************************
    assign pin_one_level = pin_one_oe_n ? keep_one : pin_one_out;
    assign pin_two_level = !pin_two_oe_n ? pin_two_out : (trig_en ? trig_lvl : keep_two);

    always_ff @(posedge clk) begin
        keep_one <= pin_one_level;
        keep_two <= pin_two_level;
    end

    // ************************************************************
    // trigger source, highs and lows of four cycles
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!trig_en) begin
            trig_cnt <= 2'h0;
            trig_lvl <= 1'b0;
        end else begin
            trig_cnt <= trig_cnt + 2'h1;
            if (trig_cnt == 2'h3) begin
                trig_lvl <= !trig_lvl;
            end
        end
    end
endmodule : irqm_host_model

// ---- verification/tb_irq_map_and_sample_config.sv ----
// self-checking testbench of the interrupt map and sample configuration block
`timescale 1ns/10ps
module tb_irq_map_and_sample_config
    import irqm_pkg::*;
;
    localparam int RC = 4;
    logic clk;
    logic rst_n;
    irqm_reg_req_s reg_req;
    irqm_status_s status;
    logic [7:0] reg_rdata;
    logic p1_out, p1_oe_n, p2_out, p2_oe_n, p1_lvl, p2_lvl;
    logic trig_en, trig_chk;
    logic rd_flag = 1'b0;
    logic pad_prev = 1'b0;
    logic [8:0] fifo_threshold;
    logic [3:0] full_scale_g;
    logic [2:0] bandwidth_divisor;
    logic conversion_start;
    logic [31:0] lfsr_state = 32'h90315337;
    logic [7:0] m1, m2, sv;
    logic [7:0] rd_q[$];
    int trig_q[$];
    int bad_count, comparisons, cyc, last_pulse, period_seen;

    irqm_config #(.RATE_CYCLES(RC)) dut_u (
        .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .status(status),
        .irq_pin_one_out(p1_out), .irq_pin_one_oe_n(p1_oe_n), .irq_pin_two_in(p2_lvl),
        .irq_pin_two_out(p2_out), .irq_pin_two_oe_n(p2_oe_n), .fifo_threshold(fifo_threshold),
        .full_scale_g(full_scale_g), .bandwidth_divisor(bandwidth_divisor), .conversion_start(conversion_start)
    );

    irqm_host_model host_u (
        .clk(clk), .pin_one_out(p1_out), .pin_one_oe_n(p1_oe_n), .pin_two_out(p2_out),
        .pin_two_oe_n(p2_oe_n), .trig_en(trig_en), .pin_one_level(p1_lvl), .pin_two_level(p2_lvl)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] rnd();
        lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
        return lfsr_state[7:0];
    endfunction : rnd

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req.addr <= a;
        reg_req.wdata <= d;
        reg_req.we <= 1'b1;
        @(posedge clk);
        reg_req.we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        reg_req.addr <= a;
        reg_req.re <= 1'b1;
        @(posedge clk);
        reg_req.re <= 1'b0;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // ************************************************************
    // clock, watchdog and output monitor
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    always @(posedge clk) begin
        cyc++;
        if (rd_flag) begin
            chk("read data", rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx, reg_rdata);
        end
        rd_flag <= reg_req.re;
        if (trig_chk && p2_lvl && !pad_prev) begin
            trig_q.push_back(cyc + 3);
        end
        pad_prev <= p2_lvl;
        if (conversion_start) begin
            if (trig_chk) begin
                chk("trigger delay", 16'(trig_q.size() > 0 ? trig_q.pop_front() : 0), 16'(cyc));
            end else begin
                period_seen = cyc - last_pulse;
                last_pulse = cyc;
            end
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rst_n = 1'b0;
        reg_req = '0;
        status = '0;
        trig_en = 1'b0;
        trig_chk = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_SAMPLE_THRESHOLD, 8'h80);
        rd(ADDR_PIN_ONE_MAP, 8'h00);
        rd(ADDR_PIN_TWO_MAP, 8'h00);
        rd(ADDR_FILTER_CONFIG, 8'h13);
        rd(ADDR_FIFO_CONFIG, 8'h00);
        settle(1);
        chk("threshold", 9'h080, fifo_threshold);
        chk("full scale", SCALE_2G, full_scale_g);
        chk("bandwidth", BW_DIV_QUARTER, bandwidth_divisor);
        chk("pin one enable", 1'b1, p1_oe_n);
        chk("pin two enable", 1'b1, p2_oe_n);
        $display("test reset done");

        wr(ADDR_FIFO_CONFIG, 8'hff);
        wr(ADDR_SAMPLE_THRESHOLD, 8'h00);
        settle(1);
        chk("threshold", 9'h100, fifo_threshold);
        rd(ADDR_FIFO_CONFIG, 8'h08);
        wr(ADDR_SAMPLE_THRESHOLD, 8'hff);
        settle(1);
        chk("threshold", 9'h1ff, fifo_threshold);
        wr(ADDR_FIFO_CONFIG, 8'hf7);
        settle(1);
        chk("threshold", 9'h0ff, fifo_threshold);
        wr(8'h2e, 8'h5a);
        rd(8'h2e, 8'h00);
        $display("test threshold done");

        for (int r = 0; r < 4; r++) begin
            wr(ADDR_FILTER_CONFIG, {r[1:0], 1'b1, r[0], 1'b0, 3'h3});
            settle(1);
            chk("full scale", r == 0 ? SCALE_2G : (r == 1 ? SCALE_4G : SCALE_8G), full_scale_g);
            chk("bandwidth", r[0] ? BW_DIV_QUARTER : BW_DIV_HALF, bandwidth_divisor);
            rd(ADDR_FILTER_CONFIG, {r[1:0], 1'b1, r[0], 1'b0, 3'h3});
            rd(ADDR_FILTER_CONFIG, {r[1:0], 1'b1, r[0], 1'b0, 3'h3});
        end
        $display("test filter done");

        for (int i = 0; i < 24; i++) begin
            m1 = rnd();
            m2 = rnd();
            sv = rnd();
            if (i % 6 == 0) begin
                m1[6:0] = 7'h00;
            end
            if (i % 7 == 3) begin
                m2[6:0] = 7'h00;
            end
            wr(ADDR_PIN_ONE_MAP, m1);
            wr(ADDR_PIN_TWO_MAP, m2);
            @(posedge clk);
            status <= irqm_status_s'(sv[6:0]);
            settle(2);
            chk("pin one enable", m1[6:0] == 7'h00, p1_oe_n);
            chk("pin two enable", m2[6:0] == 7'h00, p2_oe_n);
            if (m1[6:0] != 7'h00) begin
                chk("pin one level", (|(m1[6:0] & sv[6:0])) ^ m1[7], p1_lvl);
            end
            if (m2[6:0] != 7'h00) begin
                chk("pin two level", (|(m2[6:0] & sv[6:0])) ^ m2[7], p2_lvl);
            end
            rd(ADDR_STATUS_MIRROR, {1'b0, sv[6:0]});
            rd(ADDR_PIN_ONE_MAP, m1);
            rd(ADDR_PIN_TWO_MAP, m2);
        end
        $display("test pin map done");

        wr(ADDR_PIN_TWO_MAP, 8'h01);
        rd(ADDR_PIN_TWO_MAP, 8'h01);
        @(posedge clk);
        status <= '1;
        wr(ADDR_FILTER_CONFIG, 8'h1b);
        settle(4);
        chk("pin two enable", 1'b1, p2_oe_n);
        @(posedge clk);
        trig_chk <= 1'b1;
        trig_en <= 1'b1;
        repeat (80) @(posedge clk);
        trig_en <= 1'b0;
        repeat (10) @(posedge clk);
        trig_chk <= 1'b0;
        settle(1);
        chk("trigger leftover", 16'h0000, 16'(trig_q.size()));
        $display("test trigger done");

        for (int c = 0; c < 8; c++) begin
            wr(ADDR_FILTER_CONFIG, {5'h02, c[2:0]});
            settle(220);
            chk("rate period", 16'(c > 4 ? RC : RC << (5 - c)), 16'(period_seen));
        end
        $display("test rate done");
        settle(2);
        complete_run();
    end
endmodule : tb_irq_map_and_sample_config
